// ---- rtl/cap_sense_pkg.sv ----
// constants and carrier types for the capacitive sense control block
package cap_sense_pkg;
    // register byte addresses on the bus (word index times four)
    localparam logic [3:0] ADDR_CTRL_MAIN   = 4'h0;
    localparam logic [3:0] ADDR_CHAN_SEL    = 4'h4;
    localparam logic [3:0] ADDR_TIMER_CTRL  = 4'h8;
    localparam logic [3:0] ADDR_TIMER0_CNT  = 4'hC;
    localparam logic [3:0] ADDR_TIMER1_CNT  = 4'h0;
    localparam logic [4:0] ADDR_TIMER1_FULL = 5'h10;
    localparam logic [4:0] ADDR_SLEEP       = 5'h14;
    // field positions in sense_control_main
    localparam int BIT_ENABLE     = 7;
    localparam int BIT_RANGE_LO   = 2;
    localparam int BIT_DIRECTION  = 1;
    localparam int BIT_T0_EXT_SEL = 0;
    // field positions in the timer control register
    localparam int BIT_T0_SRC     = 0;
    localparam int BIT_T1_SRC_LO  = 1;
    localparam int BIT_T1_ON      = 3;
    localparam int BIT_T1_GATE_EN = 4;
    localparam int BIT_T1_TOGGLE  = 5;
    localparam int BIT_T1_GSRC_LO = 6;
    // reset values
    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [15:0] RESET_COUNT  = 16'h0000;
    // decoded codes
    localparam logic [1:0] T1_SRC_SENSE  = 2'h3;
    localparam logic [1:0] GSRC_PIN      = 2'h0;
    localparam logic [1:0] GSRC_T0_OVF   = 2'h1;
    localparam int         NUM_CHANNELS  = 16;

    typedef enum logic [1:0] {
        RANGE_OFF,
        RANGE_LOW,
        RANGE_MEDIUM,
        RANGE_HIGH
    } osc_range_t;

    // outputs toward the analogue front end
    typedef struct packed {
        logic        powered;
        osc_range_t  range;
        logic [15:0] channel_onehot;
    } analog_ctrl_t;
endpackage

// ---- rtl/capacitive_sense_control.sv ----
// capacitive sense control: registers, channel routing and timer clocking
// Summary of operation
// [RULE1] enable bit powers the sensing module; clear shuts it down.
// [RULE2] while disabled, channel field ignored and no input connected.
// [RULE3] enabled: 4-bit channel field routes input 0 to 15.
// [RULE4] small variant: upper eight codes select nothing, top bit reads zero; here the top bit is masked off, so those codes select inputs 0 to 7.
// [RULE5] range field: 00 off, 01 low, 10 medium, 11 high current.
// [RULE6] read-only status bit: one while sourcing, zero while sinking.
// [RULE7] external Timer0 clock: select bit picks oscillator or clock pin.
// [RULE8] internal Timer0 clock counts instruction clock, select bit ignored.
// [RULE9] Timer1 source code 11 clocks Timer1 from the oscillator.
// [RULE10] Timer1 off unless on; gated counting when gate enable set.
// [RULE11] channel change while enabled moves oscillator immediately.
// [RULE12] oscillator-clocked timer advances once per oscillator cycle.
// [RULE13] oscillator keeps running in sleep while module enabled.
// [RULE14] Timer0 does not count during sleep.
// [RULE15] window must come from a timer other than the counted one.
// [RULE16] recommended window: Timer1 gate toggle from Timer0 overflow.
// [RULE17] unused upper control bits read zero.
// [RULE18] gate toggle flip-flop inverts on each rising gate-source edge.
// [RULE19] gate source 01 takes the Timer0 overflow.
// [RULE20] all writable fields clear on reset.
// [RULE21] oscillator output synchronised before use.
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module capacitive_sense_control #(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    input  wire logic [4:0]                  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic                        osc_out,
    input  wire logic                        timer0_clock_pin,
    input  wire logic                        timer1_gate_pin,
    input  wire logic                        instr_tick,
    output cap_sense_pkg::analog_ctrl_t      analog_ctrl,
    output logic                             timer0_overflow
);
    import cap_sense_pkg::*;

    // ==================================================================
    // overview
    // the block holds the two sense control registers, a timer control
    // register, a sleep bit and the two counters that the oscillator can
    // clock. everything runs on core_clk; the oscillator, the Timer0 clock
    // pin, the Timer1 gate pin and the instruction tick all arrive from
    // outside this clock domain and pass two flip-flops first.
    // counting happens on synchronised rising edges of the oscillator, so
    // the oscillator must run well below half of core_clk or edges merge
    // and the count reads low. that limit is the price of keeping a single
    // clock domain in place of a counter clocked by the oscillator itself.
    // the analogue controls are registered, so a field write reaches the
    // front end one edge after the write edge, never part-way through.
    // software sees every register in the low bits of a 32-bit word; the
    // unused upper bits always read zero and ignore writes.
    // the measurement window is the business of software: it must come
    // from a timer other than the one that the oscillator is clocking.

    // ==================================================================
    // register state
    logic [7:0]  main_reg;
    logic [3:0]  chan_reg;
    logic [7:0]  tctrl_reg;
    logic        sleep_reg;
    logic [7:0]  t0_count_reg;
    logic [15:0] t1_count_reg;
    logic        gate_toggle_reg;
    logic        answer_pending_reg;
    logic        waitrequest_reg;
    logic [31:0] readdata_reg;
    analog_ctrl_t analog_reg;
    logic        t0_ovf_reg;

    // ==================================================================
    // synchronisers and edge detection
    logic [1:0] osc_sync_reg;
    logic [1:0] pin_sync_reg;
    logic [1:0] gpin_sync_reg;
    logic [1:0] tick_sync_reg;
    logic       osc_prev_reg;
    logic       pin_prev_reg;
    logic       gsrc_prev_reg;

    // two stages per asynchronous input
    // only the second stage is ever read by logic; the first stage may be
    // metastable and must not fan out. the stages carry no reset because
    // reset is held long enough for them to flush before use.
    always_ff @(posedge core_clk) begin
        osc_sync_reg  <= {osc_sync_reg[0], osc_out};        // see [RULE21]
        pin_sync_reg  <= {pin_sync_reg[0], timer0_clock_pin};
        gpin_sync_reg <= {gpin_sync_reg[0], timer1_gate_pin};
        tick_sync_reg <= {tick_sync_reg[0], instr_tick};
        osc_prev_reg  <= osc_sync_reg[1];
        pin_prev_reg  <= pin_sync_reg[1];
    end

    wire osc_level = osc_sync_reg[1];
    wire osc_rise  = osc_level & ~osc_prev_reg;             // see [RULE12]
    wire pin_rise  = pin_sync_reg[1] & ~pin_prev_reg;
    wire tick      = tick_sync_reg[1];

    // ==================================================================
    // field decode
    // every field is a named slice of its register, so the decode takes its
    // bit positions from the package and the counters read plain single wires.
    wire       enable     = main_reg[BIT_ENABLE];
    wire [1:0] range_fld  = main_reg[BIT_RANGE_LO +: 2];
    wire       t0_ext_sel = main_reg[BIT_T0_EXT_SEL];
    wire       t0_src     = tctrl_reg[BIT_T0_SRC];
    wire [1:0] t1_src     = tctrl_reg[BIT_T1_SRC_LO +: 2];
    wire       t1_on      = tctrl_reg[BIT_T1_ON];
    wire       t1_gate_en = tctrl_reg[BIT_T1_GATE_EN];
    wire       t1_toggle  = tctrl_reg[BIT_T1_TOGGLE];
    wire [1:0] t1_gsrc    = tctrl_reg[BIT_T1_GSRC_LO +: 2];
    // oscillator runs only with module on and a nonzero range
    wire       osc_active = enable & (range_fld != 2'h0);   // see [RULE13]
    wire       osc_step   = osc_active & osc_rise;
    // small package keeps the top channel bit at zero
    wire [3:0] chan_mask  = SMALL_PACKAGE ? 4'h7 : 4'hF;    // see [RULE4]

    // ==================================================================
    // channel routing, one-hot per input
    // with the module off every select line stays low, whatever code sits
    // in the channel register; with it on exactly one line is high, so
    // two pads are never joined through the input switches.
    logic [15:0] onehot_next;
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
            assign onehot_next[ch] = enable && (chan_reg == 4'(ch)); // see [RULE2] [RULE3]
        end
    endgenerate

    // ==================================================================
    // Timer0 clocking
    // external source picks oscillator or pin; internal counts ticks
    wire t0_ext_step = t0_ext_sel ? osc_step : pin_rise;    // see [RULE7]
    wire t0_step     = (t0_src ? t0_ext_step : tick)        // see [RULE8]
                       & ~sleep_reg;                        // see [RULE14]

    // ==================================================================
    // Timer1 clocking and gate
    // in toggle mode the gate flip-flop flips on every rising edge of the
    // gate source, so one source period becomes one counting window.
    // outside toggle mode the gate is the source level, active high.
    wire t1_step_src = (t1_src == T1_SRC_SENSE) ? osc_step : tick; // see [RULE9]
    wire gsrc_level  = (t1_gsrc == GSRC_T0_OVF) ? t0_ovf_reg       // see [RULE19]
                     : gpin_sync_reg[1];
    wire gsrc_rise   = gsrc_level & ~gsrc_prev_reg;
    wire gate_open   = t1_toggle ? gate_toggle_reg : gsrc_level;
    wire t1_run      = t1_on & (~t1_gate_en | gate_open);   // see [RULE10]
    wire t1_step     = t1_run & t1_step_src;

    // ==================================================================
    // bus decode
    wire access     = avs_read | avs_write;
    wire take       = access & answer_pending_reg;
    wire wr         = avs_write & take;
    wire [4:0] addr = avs_address;
    wire wr_main    = wr && (addr == {1'b0, ADDR_CTRL_MAIN});
    wire wr_chan    = wr && (addr == {1'b0, ADDR_CHAN_SEL});
    wire wr_tctrl   = wr && (addr == {1'b0, ADDR_TIMER_CTRL});
    wire wr_t0      = wr && (addr == {1'b0, ADDR_TIMER0_CNT});
    wire wr_t1      = wr && (addr == ADDR_TIMER1_FULL);
    wire wr_sleep   = wr && (addr == ADDR_SLEEP);
    // unimplemented bits read zero; status bit is live
    wire [7:0] main_view = {main_reg[7], 3'h0, main_reg[3:2], // see [RULE17]
                            osc_level & osc_active, main_reg[0]}; // see [RULE6]
    logic [31:0] rd_mux;
    always_comb begin
        unique case (addr)
            {1'b0, ADDR_CTRL_MAIN}:  rd_mux = {24'h000000, main_view};
            {1'b0, ADDR_CHAN_SEL}:   rd_mux = {28'h0000000, chan_reg};
            {1'b0, ADDR_TIMER_CTRL}: rd_mux = {24'h000000, tctrl_reg};
            {1'b0, ADDR_TIMER0_CNT}: rd_mux = {24'h000000, t0_count_reg};
            ADDR_TIMER1_FULL:        rd_mux = {16'h0000, t1_count_reg};
            ADDR_SLEEP:              rd_mux = {31'h00000000, sleep_reg};
            default:                 rd_mux = 32'h00000000;
        endcase
    end

    // ==================================================================
    // bus handshake: one wait cycle then the answer
    // read data is captured in the wait cycle and stands through the
    // answer cycle; waitrequest is its own flop so the port has no logic
    // between the register and the pin.
    wire answer_next = access & ~answer_pending_reg;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            answer_pending_reg <= 1'b0;
            waitrequest_reg    <= 1'b1;
            readdata_reg       <= 32'h00000000;
        end else begin
            answer_pending_reg <= answer_next;
            waitrequest_reg    <= ~answer_next;
            if (access & ~answer_pending_reg) begin
                readdata_reg <= rd_mux;
            end
        end
    end

    // control registers
    // writes land at the edge that ends the answer cycle; the status bit
    // and the unused bits are never stored, so they cannot be written.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            main_reg  <= RESET_BYTE;                        // see [RULE20]
            chan_reg  <= 4'h0;
            tctrl_reg <= RESET_BYTE;
            sleep_reg <= 1'b0;
        end else begin
            if (wr_main) begin
                main_reg <= {avs_writedata[7], 3'h0, avs_writedata[3:2], 1'b0,
                             avs_writedata[0]};             // see [RULE1] [RULE5]
            end
            if (wr_chan) begin
                chan_reg <= avs_writedata[3:0] & chan_mask; // see [RULE4]
            end
            if (wr_tctrl) begin
                tctrl_reg <= avs_writedata[7:0];
            end
            if (wr_sleep) begin
                sleep_reg <= avs_writedata[0];
            end
        end
    end

    // Timer0 counter with overflow pulse
    // a software write beats an increment in the same cycle; the overflow
    // pulse lasts one cycle and feeds the Timer1 gate source selector.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            t0_count_reg <= RESET_BYTE;
            t0_ovf_reg   <= 1'b0;
        end else begin
            t0_ovf_reg <= t0_step && (t0_count_reg == 8'hFF);
            if (wr_t0) begin
                t0_count_reg <= avs_writedata[7:0];
            end else if (t0_step) begin
                t0_count_reg <= t0_count_reg + 8'h01;
            end
        end
    end

    // gate toggle flip-flop, cleared when toggle mode is off
    always_ff @(posedge core_clk) begin
        if (reset) begin
            gsrc_prev_reg   <= 1'b0;
            gate_toggle_reg <= 1'b0;
        end else begin
            gsrc_prev_reg <= gsrc_level;
            if (!t1_toggle) begin
                gate_toggle_reg <= 1'b0;
            end else if (gsrc_rise) begin
                gate_toggle_reg <= ~gate_toggle_reg;        // see [RULE18] [RULE16]
            end
        end
    end

    // Timer1 counter, one count per source step
    // keeps counting in sleep, which is what lets a measurement run while
    // the core is asleep; a write beats an increment in the same cycle.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            t1_count_reg <= RESET_COUNT;
        end else if (wr_t1) begin
            t1_count_reg <= avs_writedata[15:0];
        end else if (t1_step) begin
            t1_count_reg <= t1_count_reg + 16'h0001;        // see [RULE12] [RULE15]
        end
    end

    // analogue controls follow the fields on the next edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            analog_reg <= '0;
        end else begin
            analog_reg.powered        <= enable;            // see [RULE1]
            analog_reg.range          <= enable ? osc_range_t'(range_fld) : RANGE_OFF;
            analog_reg.channel_onehot <= onehot_next;       // see [RULE11]
        end
    end

    assign avs_readdata    = readdata_reg;
    // ==================================================================
    // outputs, each straight from its flop
    assign avs_waitrequest = waitrequest_reg;
    assign analog_ctrl     = analog_reg;
    assign timer0_overflow = t0_ovf_reg;
endmodule
`default_nettype wire

// ---- tb/cap_sense_properties.sv ----
// concurrent checks on the sense control ports
`timescale 1ns/1ps
`default_nettype none
module cap_sense_properties
    import cap_sense_pkg::*;
(
    input wire logic         core_clk,
    input wire logic         reset,
    input wire logic [4:0]   avs_address,
    input wire logic         avs_read,
    input wire logic         avs_write,
    input wire logic [31:0]  avs_writedata,
    input wire logic [31:0]  avs_readdata,
    input wire logic         avs_waitrequest,
    input wire analog_ctrl_t analog_ctrl
);
    // ==========
    // bus steps
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic bus_req = avs_read || avs_write;
    sequence main_wr_s;
        avs_write && !avs_waitrequest && avs_address == {1'h0, ADDR_CTRL_MAIN};
    endsequence
    sequence chan_wr_s;
        avs_write && !avs_waitrequest && avs_address == {1'h0, ADDR_CHAN_SEL};
    endsequence
    // ==========
    // assertions
    one_wait_a: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("answer not one cycle after request");
    idle_wait_a: assert property (!bus_req |-> avs_waitrequest)
        else $error("waitrequest low without request");
    off_dark_a: assert property (!analog_ctrl.powered |->
        analog_ctrl.channel_onehot == 16'h0 && analog_ctrl.range == RANGE_OFF)
        else $error("disabled module drives channel or range");
    chan_onehot_a: assert property (analog_ctrl.powered |->
        $onehot(analog_ctrl.channel_onehot)) else $error("channel not one-hot");
    enable_follow_a: assert property (main_wr_s |-> ##2
        analog_ctrl.powered == $past(avs_writedata[7], 2)) else $error("enable lost");
    range_follow_a: assert property (main_wr_s |-> ##2 (!analog_ctrl.powered ||
        analog_ctrl.range == $past(avs_writedata[3:2], 2))) else $error("range wrong");
    chan_follow_a: assert property (chan_wr_s |-> ##2 (!analog_ctrl.powered ||
        analog_ctrl.channel_onehot == 16'h1 << $past(avs_writedata[3:0], 2)))
        else $error("channel not moved");
    main_pad_a: assert property (avs_read && !avs_waitrequest &&
        avs_address == {1'h0, ADDR_CTRL_MAIN} |-> avs_readdata[31:8] == 24'h0 &&
        avs_readdata[6:4] == 3'h0) else $error("unused main bits set");
    chan_pad_a: assert property (avs_read && !avs_waitrequest &&
        avs_address == {1'h0, ADDR_CHAN_SEL} |-> avs_readdata[31:4] == 28'h0)
        else $error("unused channel bits set");
endmodule
bind capacitive_sense_control cap_sense_properties u_props (.core_clk(core_clk),
    .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .analog_ctrl(analog_ctrl));
`default_nettype wire

// ---- tb/touch_pad_model.sv ----
// touch pad model: relaxation oscillator on the selected input
`timescale 1ns/1ps
`default_nettype none
module touch_pad_model
    import cap_sense_pkg::*;
(
    input wire analog_ctrl_t analog_ctrl,
    output var logic         osc_out
);
    // ==========
    // waveform: faster with more current, held low when idle
    initial begin
        osc_out = 1'h0;
        forever begin
            case (analog_ctrl.range)
                RANGE_LOW:    #37;
                RANGE_MEDIUM: #23;
                RANGE_HIGH:   #13;
                default:      #10;
            endcase
            if (analog_ctrl.powered && analog_ctrl.range != RANGE_OFF) begin
                osc_out = !osc_out;
            end else begin
                osc_out = 1'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the capacitive sense control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cap_sense_pkg::*;
    localparam logic [4:0] A_MAIN = {1'h0, ADDR_CTRL_MAIN};
    localparam logic [4:0] A_CHAN = {1'h0, ADDR_CHAN_SEL};
    localparam logic [4:0] A_TCTL = {1'h0, ADDR_TIMER_CTRL};
    localparam logic [7:0] MAIN_T[7] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h8C, 8'h8C, 8'h8C};
    localparam logic [7:0] TCTL_T[7] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h06, 8'h0E, 8'h1E};
    localparam logic [6:0] SLP_M = 7'h28;
    localparam logic [6:0] NZ_M  = 7'h23;
    logic         core_clk = 1'h0;
    logic         reset = 1'h1;
    logic [4:0]   avs_address = 5'h0;
    logic         avs_read = 1'h0;
    logic         avs_write = 1'h0;
    logic [31:0]  avs_writedata = 32'h0;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    logic         osc_out;
    logic         t0_pin = 1'h0;
    logic         gate_pin = 1'h0;
    logic         instr_tick = 1'h0;
    analog_ctrl_t analog_ctrl;
    logic         timer0_overflow;
    int           err_total = 0;
    int           tests_run = 0;
    int           seed = 71855;
    logic [31:0]  exp_q[$];
    logic [31:0]  msk_q[$];
    logic [31:0]  e_cur;
    logic [31:0]  m_cur;
    logic [7:0]   d;
    logic [4:0]   cnt;
    always #5 core_clk = !core_clk;
    capacitive_sense_control DUT (.core_clk(core_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .osc_out(osc_out), .timer0_clock_pin(t0_pin),
        .timer1_gate_pin(gate_pin), .instr_tick(instr_tick), .analog_ctrl(analog_ctrl),
        .timer0_overflow(timer0_overflow));
    touch_pad_model pad (.analog_ctrl(analog_ctrl), .osc_out(osc_out));
    // ==========
    // shared tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] v);
        avs_address <= a;
        avs_writedata <= {24'h0, v};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge core_clk);
    endtask
    // a zero mask asks for a nonzero count
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(1'h0, a, 8'h0);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========
    // random pins and read monitor
    always @(posedge core_clk) begin
        {t0_pin, instr_tick} <= 2'($random(seed));
        if (avs_read && avs_waitrequest === 1'h0 && exp_q.size() > 0) begin
            e_cur = exp_q.pop_front();
            m_cur = msk_q.pop_front();
            if (m_cur === 32'h0) check("count", {31'h0, avs_readdata != 32'h0}, 32'h1);
            else check("readdata", avs_readdata & m_cur, e_cur);
        end
    end
    initial begin
        #500000;
        err_total++;
        print_verdict();
    end
    // ==========
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'h0;
        @(posedge core_clk);
        check("analog_ctrl", {13'h0, analog_ctrl}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            rd(5'(i * 4), 32'h0, i == 3 ? 32'hFFFFFF00 : 32'hFFFFFFFF);
        end
        repeat (8) begin
            d = 8'($random(seed));
            bus(1'h1, A_MAIN, d);
            rd(A_MAIN, {24'h0, d & 8'h8D}, 32'hFFFFFFFD);
            bus(1'h1, A_CHAN, d);
            rd(A_CHAN, {24'h0, d & 8'h0F}, 32'hFFFFFFFF);
        end
        bus(1'h1, A_MAIN, 8'h84);
        for (int c = 0; c < 16; c++) begin
            bus(1'h1, A_CHAN, 8'(c));
            @(posedge core_clk);
            check("channel", {16'h0, analog_ctrl.channel_onehot}, 32'h1 << c);
        end
        for (int r = 0; r < 8; r++) begin
            bus(1'h1, A_MAIN, {r[2], 3'h0, r[1:0], 2'h0});
            @(posedge core_clk);
            check("analog", {13'h0, analog_ctrl}, r[2] ? {13'h1, r[1:0], 16'h8000} : 32'h0);
        end
        for (int k = 0; k < 7; k++) begin
            cnt = k < 4 ? {1'h0, ADDR_TIMER0_CNT} : ADDR_TIMER1_FULL;
            bus(1'h1, A_MAIN, MAIN_T[k]);
            bus(1'h1, A_TCTL, TCTL_T[k]);
            bus(1'h1, ADDR_SLEEP, {7'h0, SLP_M[k]});
            bus(1'h1, cnt, 8'h0);
            repeat (40) @(posedge core_clk);
            rd(cnt, 32'h0, NZ_M[k] ? 32'h0 : 32'hFFFFFFFF);
        end
        // window from Timer0 overflow toggling the Timer1 gate
        bus(1'h1, {1'h0, ADDR_TIMER0_CNT}, 8'h00);
        bus(1'h1, A_TCTL, 8'h7E);
        bus(1'h1, ADDR_TIMER1_FULL, 8'h00);
        repeat (40) @(posedge core_clk);
        rd(ADDR_TIMER1_FULL, 32'h0, 32'hFFFFFFFF);
        bus(1'h1, {1'h0, ADDR_TIMER0_CNT}, 8'hF0);
        repeat (100) @(posedge core_clk);
        rd(ADDR_TIMER1_FULL, 32'h0, 32'h0);
        repeat (2) @(posedge core_clk);
        print_verdict();
    end
endmodule
`default_nettype wire
